// ===== hdl/tpcmd_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpcmd_regs.svh"

module tpcmd_core #(
    parameter logic [7:0] FW_ID_B2 = 8'h5a, // arbitrary id value
    parameter logic [7:0] FW_ID_B3 = 8'h3c, // arbitrary id value
    parameter logic [7:0] FW_ID_B4 = 8'h11  // arbitrary id value
) (
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic CMD_VALID,
    input wire tpcmd_pkg::tpcmd_pkt_t CMD_PKT,
    input wire logic TOUCH,
    output logic RSP_VALID,
    output var tpcmd_pkg::tpcmd_pkt_t RSP_PKT,
    output var tpcmd_pkg::tpcmd_mode_t MODE,
    output logic [3:0] RATE
);

    // ----------------------------------------
    // packet decode
    // ----------------------------------------
    logic is_read;
    logic rd_fwid;
    logic rd_power;
    logic wr_power;
    logic [1:0] new_ps;
    logic [3:0] new_rate;
    logic rate_ok;
    logic wr_ok;
    logic wr_hdr_ok;
    logic rsv_ok;
    logic run_b3_ok;
    logic low_b3_ok;

    function automatic logic [1:0] mode_code(tpcmd_pkg::tpcmd_mode_t m);
        case (m)
            tpcmd_pkg::TPCMD_IDLE: mode_code = `TPCMD_PS_IDLE;
            tpcmd_pkg::TPCMD_SLEEP: mode_code = `TPCMD_PS_SLEEP;
            default: mode_code = `TPCMD_PS_NORMAL;
        endcase
    endfunction

    assign is_read = CMD_VALID
        && CMD_PKT.b1 == `TPCMD_CODE_READ
        && CMD_PKT.b3 == `TPCMD_BYTE3_READ
        && CMD_PKT.b4 == `TPCMD_TAIL;
    assign rd_fwid = is_read && CMD_PKT.b2 == `TPCMD_SEL_FWID;
    assign rd_power = is_read && CMD_PKT.b2 == {`TPCMD_SEL_POWER, 4'h0};
    assign new_ps = CMD_PKT.b2[`TPCMD_PS_MSB:`TPCMD_PS_LSB];
    assign new_rate = CMD_PKT.b3[3:0];
    // only the five listed rate codes are taken
    function automatic logic valid_rate(logic [3:0] r);
        case (r)
            `TPCMD_RATE_80: valid_rate = 1'b1;
            `TPCMD_RATE_100: valid_rate = 1'b1;
            `TPCMD_RATE_115: valid_rate = 1'b1;
            `TPCMD_RATE_130: valid_rate = 1'b1;
            `TPCMD_RATE_150: valid_rate = 1'b1;
            default: valid_rate = 1'b0;
        endcase
    endfunction

    assign rate_ok = valid_rate(new_rate);
    // reserved bits must be zero; bad state code drops the packet
    assign wr_hdr_ok = CMD_VALID
        && CMD_PKT.b1 == `TPCMD_CODE_WRITE
        && CMD_PKT.b2[7:4] == `TPCMD_SEL_POWER
        && CMD_PKT.b4 == `TPCMD_TAIL;
    assign rsv_ok = CMD_PKT.b2[1:0] == 2'h0;
    assign run_b3_ok = rate_ok
        && CMD_PKT.b3[7:4] == 4'h0;
    assign low_b3_ok = CMD_PKT.b3 == 8'h00;

    always_comb begin
        case (new_ps)
            `TPCMD_PS_NORMAL: begin
                wr_ok = run_b3_ok;
            end
            `TPCMD_PS_IDLE, `TPCMD_PS_SLEEP: begin
                wr_ok = low_b3_ok;
            end
            default: begin
                // code 11 has no meaning, so the packet is dropped
                wr_ok = 1'b0;
            end
        endcase
    end

    assign wr_power = wr_hdr_ok && rsv_ok && wr_ok;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    tpcmd_pkg::tpcmd_mode_t next_mode;
    logic [3:0] next_rate;
    logic next_rsp_valid;
    tpcmd_pkg::tpcmd_pkt_t next_rsp_pkt;

    function automatic tpcmd_pkg::tpcmd_mode_t code_mode(logic [1:0] ps);
        case (ps)
            `TPCMD_PS_IDLE: begin
                code_mode = tpcmd_pkg::TPCMD_IDLE;
            end
            `TPCMD_PS_SLEEP: begin
                code_mode = tpcmd_pkg::TPCMD_SLEEP;
            end
            default: begin
                code_mode = tpcmd_pkg::TPCMD_RUN;
            end
        endcase
    endfunction

    function automatic tpcmd_pkg::tpcmd_pkt_t fwid_pkt();
        fwid_pkt.b1 = `TPCMD_CODE_RESP;
        fwid_pkt.b2 = FW_ID_B2;
        fwid_pkt.b3 = FW_ID_B3;
        fwid_pkt.b4 = FW_ID_B4;
    endfunction

    // rate field reads zero outside normal mode
    function automatic tpcmd_pkg::tpcmd_pkt_t power_pkt(
        tpcmd_pkg::tpcmd_mode_t m,
        logic [3:0] r
    );
        power_pkt.b1 = `TPCMD_CODE_RESP;
        power_pkt.b2 = {`TPCMD_SEL_POWER, mode_code(m), 2'h0};
        if (m == tpcmd_pkg::TPCMD_RUN) begin
            power_pkt.b3 = {4'h0, r};
        end else begin
            power_pkt.b3 = 8'h00;
        end
        power_pkt.b4 = `TPCMD_TAIL;
    endfunction

    // a write in the same cycle as a touch wins
    always_comb begin
        next_mode = MODE;
        if (wr_power) begin
            next_mode = code_mode(new_ps);
        end else if (TOUCH) begin
            case (MODE)
                tpcmd_pkg::TPCMD_IDLE: begin
                    next_mode = tpcmd_pkg::TPCMD_RUN;
                end
                tpcmd_pkg::TPCMD_RUN: begin
                    next_mode = tpcmd_pkg::TPCMD_RUN;
                end
                tpcmd_pkg::TPCMD_SLEEP: begin
                    // deep sleep only wakes on a command
                    next_mode = tpcmd_pkg::TPCMD_SLEEP;
                end
                default: begin
                    next_mode = tpcmd_pkg::TPCMD_RUN;
                end
            endcase
        end
    end

    always_comb begin
        next_rate = RATE;
        if (wr_power && new_ps == `TPCMD_PS_NORMAL) begin
            next_rate = new_rate;
        end
    end

    always_comb begin
        next_rsp_valid = 1'b0;
        next_rsp_pkt = RSP_PKT;
        if (rd_fwid) begin
            next_rsp_valid = 1'b1;
            next_rsp_pkt = fwid_pkt();
        end else if (rd_power) begin
            next_rsp_valid = 1'b1;
            next_rsp_pkt = power_pkt(MODE, RATE);
        end else begin
            // anything else leaves the last answer, unflagged
            next_rsp_valid = 1'b0;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            MODE <= tpcmd_pkg::TPCMD_RUN;
        end else begin
            MODE <= next_mode;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            RATE <= `TPCMD_RATE_RESET;
        end else begin
            RATE <= next_rate;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            RSP_VALID <= 1'b0;
            RSP_PKT <= '0;
        end else begin
            RSP_VALID <= next_rsp_valid;
            RSP_PKT <= next_rsp_pkt;
        end
    end

endmodule // tpcmd_core
`default_nettype wire

// ===== inc/tpcmd_regs.svh
`ifndef TPCMD_REGS_SVH
`define TPCMD_REGS_SVH

// ----------------------------------------
// packet codes and selectors
// ----------------------------------------
`define TPCMD_CODE_READ 8'h53
`define TPCMD_CODE_WRITE 8'h54
`define TPCMD_CODE_RESP 8'h52
`define TPCMD_SEL_FWID 8'hf0
`define TPCMD_SEL_POWER 4'h5
`define TPCMD_BYTE3_READ 8'h00
`define TPCMD_TAIL 8'h01

// ----------------------------------------
// power state field, byte-two low nibble bits 3..2
// ----------------------------------------
`define TPCMD_PS_MSB 3
`define TPCMD_PS_LSB 2
`define TPCMD_PS_NORMAL 2'h2
`define TPCMD_PS_IDLE 2'h1
`define TPCMD_PS_SLEEP 2'h0

// ----------------------------------------
// report rate codes
// ----------------------------------------
`define TPCMD_RATE_80 4'hf
`define TPCMD_RATE_100 4'ha
`define TPCMD_RATE_115 4'h7
`define TPCMD_RATE_130 4'h5
`define TPCMD_RATE_150 4'h3
`define TPCMD_RATE_RESET 4'ha

`endif

// ===== inc/tpcmd_pkg.sv
package tpcmd_pkg;

    typedef struct packed {
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
        logic [7:0] b4;
    } tpcmd_pkt_t;

    typedef enum logic [2:0] {
        TPCMD_RUN = 3'b001,
        TPCMD_IDLE = 3'b010,
        TPCMD_SLEEP = 3'b100
    } tpcmd_mode_t;

endpackage

// ===== testbench/tpcmd_host.sv
`timescale 1ns/1ps
`default_nettype none
module tpcmd_host (
    input wire logic clk,
    output var logic valid,
    output var tpcmd_pkg::tpcmd_pkt_t pkt
);
    initial valid = 1'b0;
    initial pkt = 32'h0;
    // whole packet per cycle; bus scrambled once released
    task automatic send(input logic [31:0] p);
        @(posedge clk) valid <= 1'b1;
        pkt <= p;
        @(posedge clk) valid <= 1'b0;
        pkt <= ~p;
        #1;
    endtask
endmodule // tpcmd_host
`default_nettype wire

// ===== testbench/tpcmd_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tpcmd_core_asserts (
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic CMD_VALID,
    input wire tpcmd_pkg::tpcmd_pkt_t CMD_PKT,
    input wire logic TOUCH,
    input wire logic RSP_VALID,
    input wire tpcmd_pkg::tpcmd_pkt_t RSP_PKT,
    input wire tpcmd_pkg::tpcmd_mode_t MODE,
    input wire logic [3:0] RATE
);
    wire logic [31:0] c = CMD_VALID ? CMD_PKT : 32'h0;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    property p_tch; TOUCH && MODE == 3'h2 && !c |=> MODE == 3'h1; endproperty
    a_tch: assert property (p_tch) else $error("touch");
    property p_run; MODE == 3'h2 && c == 32'h54580a01 |=> MODE == 3'h1; endproperty
    a_run: assert property (p_run) else $error("wake");
    property p_slp; c == 32'h54500001 |=> MODE == 3'h4; endproperty
    a_slp: assert property (p_slp) else $error("sleep");
    property p_fw; c == 32'h53f00001 |=> RSP_VALID && RSP_PKT[31:24] == 8'h52; endproperty
    a_fw: assert property (p_fw) else $error("fw reply");
    property p_idl; c == 32'h54540001 |=> MODE == 3'h2; endproperty
    a_idl: assert property (p_idl) else $error("idle");
    property p_rt; c == 32'h54580701 |=> RATE == 4'h7; endproperty
    a_rt: assert property (p_rt) else $error("rate");
    property p_ign; c[31:24] == 8'h55 && !TOUCH |=> !RSP_VALID && $stable(MODE); endproperty
    a_ign: assert property (p_ign) else $error("ignore");
endmodule // tpcmd_core_asserts
bind tpcmd_core tpcmd_core_asserts i_tpcmd_core_asserts (.CORE_CLK, .RSTN,
    .CMD_VALID, .CMD_PKT, .TOUCH, .RSP_VALID, .RSP_PKT, .MODE, .RATE);
`default_nettype wire

// ===== testbench/tpcmd_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tpcmd_core_tb;
    logic core_clk = 1'b0, rstn = 1'b0, touch = 1'b0, cmd_valid, rsp_valid;
    logic [3:0] rate;
    logic [3:0] rates [5] = '{4'hf, 4'ha, 4'h7, 4'h5, 4'h3};
    tpcmd_pkg::tpcmd_pkt_t cmd_pkt, rsp_pkt;
    tpcmd_pkg::tpcmd_mode_t mode;
    int fails = 0, compares = 0;
    tpcmd_host i_tpcmd_host (.clk(core_clk), .valid(cmd_valid), .pkt(cmd_pkt));
    tpcmd_core i_tpcmd_core (.CORE_CLK(core_clk), .RSTN(rstn),
        .CMD_VALID(cmd_valid), .CMD_PKT(cmd_pkt), .TOUCH(touch),
        .RSP_VALID(rsp_valid), .RSP_PKT(rsp_pkt), .MODE(mode), .RATE(rate));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic give_verdict;
        if (fails == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [31:0] p, input logic [31:0] m);
        i_tpcmd_host.send(p);
        chk("mode", m, 32'(mode));
    endtask
    task automatic tap; // touch held for one sampling edge
        @(posedge core_clk) touch <= 1'b1;
        @(posedge core_clk) touch <= 1'b0;
        #1;
    endtask
    task automatic t_read;
        i_tpcmd_host.send(32'h53f00001);
        chk("fw", 32'h525a3c11, rsp_valid ? rsp_pkt : 32'h0);
        i_tpcmd_host.send(32'h53500001);
        chk("ps", 32'h52580a01, rsp_valid ? rsp_pkt : 32'h0);
    endtask
    task automatic t_power;
        wr(32'h54540001, 32'h2);
        i_tpcmd_host.send(32'h53500001);
        chk("ps", 32'h52540001, rsp_valid ? rsp_pkt : 32'h0);
        tap;
        chk("touch", 32'h1, 32'(mode));
        wr(32'h54500001, 32'h4);
        tap;
        chk("asleep", 32'h4, 32'(mode));
        wr(32'h54540001, 32'h2);
        wr(32'h54500001, 32'h4);
        foreach (rates[i]) begin
            wr({16'h5458, 4'h0, rates[i], 8'h01}, 32'h1);
            chk("rate", 32'(rates[i]), 32'(rate));
        end
    endtask
    task automatic t_ignore;
        i_tpcmd_host.send(32'h55580a01);
        chk("code", 32'h0, 32'(rsp_valid));
        i_tpcmd_host.send(32'h53600001);
        chk("sel", 32'h0, 32'(rsp_valid));
        i_tpcmd_host.send(32'h54580201);
        chk("bad", 32'h3, 32'(rate));
    endtask
    task automatic t_reset; // second reset in mid-run
        @(posedge core_clk) rstn <= 1'b0;
        @(posedge core_clk) rstn <= 1'b1;
        #1;
        chk("mode", 32'h1, 32'(mode));
        chk("rate", 32'ha, 32'(rate));
        i_tpcmd_host.send(32'h53500001);
        chk("ps", 32'h52580a01, rsp_valid ? rsp_pkt : 32'h0);
    endtask
    initial forever #2.5 core_clk = ~core_clk;
    initial begin
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        t_read;
        t_power;
        t_ignore;
        t_reset;
        give_verdict;
    end
    initial begin // whole run is under 100 cycles
        repeat (400) @(posedge core_clk);
        fails++;
        give_verdict;
    end
endmodule // tpcmd_core_tb
`default_nettype wire
